// ===== design/ddim_pkg.sv
/*
  Package for the DMA-completion interrupt mask block: register offsets,
  implemented-bit mask, reset values and the carrier structs.
  Assumes a 32-bit word register port with byte offsets as printed.
*/
package ddim_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SRC_W  = 16;

  // register offsets
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h8c;
  localparam logic [7:0] OFF_MASK_SET      = 8'h90;
  localparam logic [7:0] OFF_MASK_CLEAR    = 8'h94;
  localparam logic [7:0] OFF_IRQ_CLEAR     = 8'h9c;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'ha0;
  localparam logic [7:0] OFF_RAW_STATUS    = 8'ha4;
  localparam logic [7:0] OFF_TRIG_SELECT   = 8'hb0;
  // block-local interrupt status and mask (one disables) of the unmapped-access and source-completion events
  localparam logic [7:0] OFF_EVT_STATUS    = 8'hc0;
  localparam logic [7:0] OFF_EVT_MASK      = 8'hc4;

  // implemented source bits and reset values
  localparam logic [15:0] SRC_IMPL_MASK   = 16'hff0f;
  localparam logic [15:0] MASK_RESET      = 16'hff0f;
  localparam logic [31:0] TRIG_SEL_RESET  = 32'h0000_0000;
  localparam logic [31:0] TRIG_SEL_IMPL   = 32'hffff_ffff;
  localparam logic [1:0]  EVT_MASK_RESET  = 2'h3;

  // source bit positions
  localparam int unsigned BIT_CONV_CH6       = 15;
  localparam int unsigned BIT_CONV_CH4       = 14;
  localparam int unsigned BIT_CONV_CH2       = 13;
  localparam int unsigned BIT_CONV_CH0       = 12;
  localparam int unsigned BIT_AUDIO_WRITE    = 11;
  localparam int unsigned BIT_AUDIO_READ     = 10;
  localparam int unsigned BIT_CAM_FIFO_EMPTY = 9;
  localparam int unsigned BIT_CAM_THRESHOLD  = 8;
  localparam int unsigned BIT_APP_SER_WRITE  = 3;
  localparam int unsigned BIT_APP_SER_READ   = 2;
  localparam int unsigned BIT_CARD_WRITE     = 1;
  localparam int unsigned BIT_CARD_READ      = 0;

  // event status bits
  localparam int unsigned EVT_UNMAPPED = 0;
  localparam int unsigned EVT_SRC_DONE = 1;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ddim_req_s;

  typedef struct packed {
    logic [SRC_W-1:0] done;
  } ddim_src_s;

endpackage

// ===== design/ddim_flag_bank.sv
`timescale 1ns/100ps
/*
  Bank of sticky flags: hardware set pulses, software write-one-to-clear.
  Assumes set and clear are synchronous to clk; set wins over clear.
*/
module ddim_flag_bank #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL = '1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // set and clear
  input  wire logic [WIDTH-1:0] set_pulse,
  input  wire logic [WIDTH-1:0] clear_ones,
  // state
  output logic      [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  // an event landing on the clear cycle is kept
  assign flags_d = ((flags_q & ~clear_ones) | set_pulse) & IMPL;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// ===== design/ddim_top.sv
`timescale 1ns/100ps
/*
  DMA-completion interrupt mask block: mask register with set and clear
  aliases, raw and masked completion status, status clear, a timer trigger
  select word and a small block-event interrupt.
  Assumes one clock, a plain register port with read data one cycle late,
  and completion pulses from the peripheral DMA channels on src.done.
*/
// Overview of operation
// - decode nine registers at documented offsets
// - mask resets to ff0f, implemented bits only
// - bits 15..12 gate converter channels 6,4,2,0
// - mask zero enables, one disables
// - bit 11 audio write, bit 10 read
// - bit 9 camera empty, bit 8 threshold
// - bits 3..0 serial and card transfers
// - set alias ones set mask bits
// - clear alias ones clear mask bits
module ddim_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire ddim_pkg::ddim_req_s           req,
  output logic      [ddim_pkg::DATA_W-1:0]   rdata_q,
  // completion sources
  input  wire ddim_pkg::ddim_src_s           src,
  // per-source gated interrupt lines and trigger select
  output logic      [ddim_pkg::SRC_W-1:0]    src_irq,
  output logic      [ddim_pkg::DATA_W-1:0]   trig_select,
  // combined interrupt
  output logic                               dma_done_irq,
  output logic                               block_irq
);

  typedef enum logic [2:0] {
    DDIM_ACC_IDLE  = 3'h1,
    DDIM_ACC_WRITE = 3'h2,
    DDIM_ACC_READ  = 3'h4
  } ddim_acc_e;

  logic [ddim_pkg::SRC_W-1:0]  mask_q;
  logic [ddim_pkg::SRC_W-1:0]  mask_d;
  logic [ddim_pkg::SRC_W-1:0]  raw_status;
  logic [ddim_pkg::SRC_W-1:0]  masked_status;
  logic [ddim_pkg::SRC_W-1:0]  irq_clear_ones;
  logic [ddim_pkg::DATA_W-1:0] trig_q;
  logic [ddim_pkg::DATA_W-1:0] rdata_d;
  logic [1:0]                  evt_status;
  logic [1:0]                  evt_set;
  logic [1:0]                  evt_clear;
  logic [1:0]                  evt_mask_q;
  logic                        hit;
  logic                        src_rise_any;
  ddim_acc_e                   acc;

  // keep only implemented source positions of a bus word
  function automatic logic [ddim_pkg::SRC_W-1:0] src_bits(
    input logic [ddim_pkg::DATA_W-1:0] w
  );
    src_bits = w[ddim_pkg::SRC_W-1:0] & ddim_pkg::SRC_IMPL_MASK;
  endfunction

  // offset decode shared by reads and writes
  function automatic logic is_mapped(input logic [ddim_pkg::ADDR_W-1:0] a);
    case (a)
      ddim_pkg::OFF_IRQ_MASK,
      ddim_pkg::OFF_MASK_SET,
      ddim_pkg::OFF_MASK_CLEAR,
      ddim_pkg::OFF_IRQ_CLEAR,
      ddim_pkg::OFF_MASKED_STATUS,
      ddim_pkg::OFF_RAW_STATUS,
      ddim_pkg::OFF_TRIG_SELECT,
      ddim_pkg::OFF_EVT_STATUS,
      ddim_pkg::OFF_EVT_MASK: is_mapped = 1'b1;
      default:                is_mapped = 1'b0;
    endcase
  endfunction

  always_comb begin
    if (req.wr) begin
      acc = DDIM_ACC_WRITE;
    end else if (req.rd) begin
      acc = DDIM_ACC_READ;
    end else begin
      acc = DDIM_ACC_IDLE;
    end
  end

  assign hit = is_mapped(req.addr);

  // mask register
  always_comb begin
    mask_d = mask_q;
    if (acc == DDIM_ACC_WRITE) begin
      case (req.addr)
        ddim_pkg::OFF_IRQ_MASK:   mask_d = src_bits(req.wdata);
        ddim_pkg::OFF_MASK_SET:   mask_d = mask_q | src_bits(req.wdata);
        ddim_pkg::OFF_MASK_CLEAR: mask_d = mask_q & ~src_bits(req.wdata);
        default:                  mask_d = mask_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= ddim_pkg::MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // timer trigger select: plain read/write word, not used inside
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_q <= ddim_pkg::TRIG_SEL_RESET;
    end else if (acc == DDIM_ACC_WRITE && req.addr == ddim_pkg::OFF_TRIG_SELECT) begin
      trig_q <= req.wdata & ddim_pkg::TRIG_SEL_IMPL;
    end
  end

  assign trig_select = trig_q;

  // raw completion flags, write-one-to-clear at the status clear offset
  assign irq_clear_ones = (acc == DDIM_ACC_WRITE && req.addr == ddim_pkg::OFF_IRQ_CLEAR)
                          ? src_bits(req.wdata) : '0;

  ddim_flag_bank #(
    .WIDTH (ddim_pkg::SRC_W),
    .IMPL  (ddim_pkg::SRC_IMPL_MASK)
  ) u_raw (
    .clk        (clk),
    .rst        (rst),
    .set_pulse  (src.done),
    .clear_ones (irq_clear_ones),
    .flags_q    (raw_status)
  );

  assign masked_status = raw_status & ~mask_q;

  // per-source lines; bit positions follow the source layout:
  // converter channels at 15..12
  // audio port at 11 and 10
  assign src_irq      = masked_status;
  assign dma_done_irq = |masked_status;

  // block events: access to an unmapped offset, and any new completion
  assign src_rise_any = |(src.done & ddim_pkg::SRC_IMPL_MASK);
  always_comb begin
    evt_set = '0;
    evt_set[ddim_pkg::EVT_UNMAPPED] = (acc != DDIM_ACC_IDLE) && !hit;
    evt_set[ddim_pkg::EVT_SRC_DONE] = src_rise_any;
  end

  assign evt_clear = (acc == DDIM_ACC_WRITE && req.addr == ddim_pkg::OFF_EVT_STATUS)
                     ? req.wdata[1:0] : 2'h0;

  ddim_flag_bank #(
    .WIDTH (2),
    .IMPL  (2'h3)
  ) u_evt (
    .clk        (clk),
    .rst        (rst),
    .set_pulse  (evt_set),
    .clear_ones (evt_clear),
    .flags_q    (evt_status)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_mask_q <= ddim_pkg::EVT_MASK_RESET;
    end else if (acc == DDIM_ACC_WRITE && req.addr == ddim_pkg::OFF_EVT_MASK) begin
      evt_mask_q <= req.wdata[1:0];
    end
  end

  // event mask uses the same sense as the source mask: one disables
  assign block_irq = |(evt_status & ~evt_mask_q);

  // read data; set and clear aliases and the clear register read zero
  always_comb begin
    rdata_d = '0;
    if (acc == DDIM_ACC_READ) begin
      case (req.addr)
        ddim_pkg::OFF_IRQ_MASK:      rdata_d[ddim_pkg::SRC_W-1:0] = mask_q;
        ddim_pkg::OFF_MASKED_STATUS: rdata_d[ddim_pkg::SRC_W-1:0] = masked_status;
        ddim_pkg::OFF_RAW_STATUS:    rdata_d[ddim_pkg::SRC_W-1:0] = raw_status;
        ddim_pkg::OFF_TRIG_SELECT:   rdata_d = trig_q;
        ddim_pkg::OFF_EVT_STATUS:    rdata_d[1:0] = evt_status;
        ddim_pkg::OFF_EVT_MASK:      rdata_d[1:0] = evt_mask_q;
        default:                     rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

// ===== sim/ddim_chk.sv
/*
  Checker for the completion interrupt mask block.
  Assumes it is bound to ddim_top and sees only its ports.
*/
`timescale 1ns/100ps
module ddim_chk (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // register port and sources
  input wire ddim_pkg::ddim_req_s req,
  input wire logic [31:0]         rdata_q,
  input wire ddim_pkg::ddim_src_s src,
  // outputs
  input wire logic [15:0]         src_irq,
  input wire logic [31:0]         trig_select,
  input wire logic                dma_done_irq,
  input wire logic                block_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst;
    disable iff (1'b0) rst |-> rdata_q == 32'h0 && src_irq == 16'h0 && !dma_done_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
  property p_set;
    req.wr && req.addr == ddim_pkg::OFF_MASK_SET |=> (src_irq & $past(req.wdata[15:0])) == 16'h0;
  endproperty
  a_set: assert property (p_set) else $error("set alias left source open");
  property p_clr;
    req.wr && req.addr == ddim_pkg::OFF_MASK_CLEAR |=>
      (src_irq & $past(req.wdata[15:0] & src.done)) == $past(req.wdata[15:0] & src.done & 16'hff0f);
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias left source shut");
  property p_mis;
    req.rd && req.addr == ddim_pkg::OFF_MASKED_STATUS |=> rdata_q == {16'h0, $past(src_irq)};
  endproperty
  a_mis: assert property (p_mis) else $error("masked status read wrong");
  property p_unmap;
    req.rd && req.addr < ddim_pkg::OFF_IRQ_MASK |=> rdata_q == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_idle;
    !req.rd |=> rdata_q == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_trig;
    req.wr && req.addr == ddim_pkg::OFF_TRIG_SELECT |=> trig_select == $past(req.wdata);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger select not written");
  property p_rsv;
    (src_irq & ~ddim_pkg::SRC_IMPL_MASK) == 16'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved source active");
  property p_or;
    dma_done_irq == (|src_irq);
  endproperty
  a_or: assert property (p_or) else $error("combined line disagrees");
  c_mis: cover property (req.rd && req.addr == ddim_pkg::OFF_MASKED_STATUS ##1 rdata_q != 0);
  c_set: cover property (req.wr && req.addr == ddim_pkg::OFF_MASK_SET);
  c_irq: cover property ($rose(dma_done_irq));
endmodule
bind ddim_top ddim_chk u_chk (.clk(clk), .rst(rst), .req(req), .rdata_q(rdata_q), .src(src),
  .src_irq(src_irq), .trig_select(trig_select), .dma_done_irq(dma_done_irq),
  .block_irq(block_irq));

// ===== sim/tb_top.sv
/*
  Self-checking bench for the completion interrupt mask block.
  Assumes the checker file is compiled alongside; drives all ports itself.
*/
`timescale 1ns/100ps
module tb_top;
  logic                clk;
  logic                rst;
  ddim_pkg::ddim_req_s req;
  ddim_pkg::ddim_src_s src;
  logic [31:0]         rdata_q, trig_select, seed;
  logic [15:0]         src_irq, m, raw;
  logic                dma_done_irq, block_irq;
  int                  err_total = 0, checks_done = 0, cyc = 0;
  ddim_top dut (.clk(clk), .rst(rst), .req(req), .rdata_q(rdata_q), .src(src),
    .src_irq(src_irq), .trig_select(trig_select), .dma_done_irq(dma_done_irq),
    .block_irq(block_irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // next mask after a write, reserved bits never stick
  function automatic logic [15:0] nm(input logic [7:0] a, input logic [31:0] d);
    case (a)
      8'h8c: return d[15:0] & 16'hff0f;
      8'h90: return m | (d[15:0] & 16'hff0f);
      8'h94: return m & ~d[15:0];
      default: return m;
    endcase
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= '0;
    raw = raw | (v & 16'hff0f);
    #1;
  endtask
  initial begin
    rst = 1'b1;
    req = '0;
    src = '0;
    seed = 32'h5e4d0e78;
    m = 16'hff0f;
    raw = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h8c, 0); chk(rdata_q, 32'hff0f);
    bus(0, 8'hb0, 0); chk(rdata_q, 0);
    $display("test reset values done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      bus(1, (seed[31]) ? 8'h8c + {seed[30], 2'b0} : 8'h94, seed);
      m = nm((seed[31]) ? 8'h8c + {seed[30], 2'b0} : 8'h94, seed);
      bus(0, 8'h8c, 0); chk(rdata_q, {16'h0, m});
    end
    $display("test alias writes done");
    // clear alias opens sources completing alongside
    bus(1, 8'h8c, 32'hff0f);
    m = 16'hff0f;
    @(posedge clk);
    src <= 16'hff0f;
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h94, wdata: 32'h00f0_3005};
    @(posedge clk);
    src <= '0;
    req <= '0;
    #1;
    m = nm(8'h94, 32'h00f0_3005);
    raw = 16'hff0f;
    chk(32'(src_irq), 32'(raw & ~m));
    // set alias shuts a pending source
    bus(1, 8'h90, 32'h1000);
    m = nm(8'h90, 32'h1000);
    chk(32'(src_irq), 32'(raw & ~m));
    bus(1, 8'h9c, 32'hffff);
    raw = '0;
    for (int b = 0; b < 16; b++) begin
      seed = xs(seed);
      bus(1, 8'h8c, ~(32'h1 << b));
      m = nm(8'h8c, ~(32'h1 << b));
      pulse(seed[15:0] | (16'h1 << b));
      chk(32'(src_irq), 32'(raw & ~m));
      chk(32'(dma_done_irq), 32'(|(raw & ~m)));
      bus(0, 8'ha4, 0); chk(rdata_q, 32'(raw));
      bus(0, 8'ha0, 0); chk(rdata_q, 32'(raw & ~m));
      bus(1, 8'h9c, 32'hffff);
      raw = '0;
    end
    $display("test source gating done");
    bus(1, 8'hb0, seed); chk(trig_select, seed);
    // reserved offsets are only ever read
    bus(0, 8'h80, 0);
    chk(rdata_q, 0);
    bus(0, 8'hfc, 0);
    chk(rdata_q, 0);
    bus(0, 8'h90, 0); chk(rdata_q, 0);
    bus(1, 8'hc4, 32'h2); chk(32'(block_irq), 32'h1);
    bus(1, 8'hc4, 32'h3); chk(32'(block_irq), 32'h0);
    bus(1, 8'hc0, 32'h3); bus(1, 8'hc4, 32'h0); chk(32'(block_irq), 32'h0);
    $display("test unmapped access done");
    conclude();
  end
endmodule
